// ---- src/vrms_params.svh ----
// Constants for the reference setpoint, margin select and slew ramp block.
`ifndef VRMS_PARAMS_SVH
`define VRMS_PARAMS_SVH

// Command selectors on the internal register write/read port.
`define VRMS_CMD_W             3
`define VRMS_CMD_OPERATION     3'h0
`define VRMS_CMD_NOMINAL       3'h1
`define VRMS_CMD_UPPER_TRIM    3'h2
`define VRMS_CMD_LOWER_TRIM    3'h3
`define VRMS_CMD_VENDOR_CFG    3'h4
`define VRMS_CMD_MFR_RESET     3'h5

// Field positions.
`define VRMS_OP_ON_BIT         7
`define VRMS_OP_MARGIN_HI_BIT  5
`define VRMS_OP_MARGIN_LO_BIT  4
`define VRMS_SETPOINT_W        9
`define VRMS_CFG_MULT_MSB      1
`define VRMS_CFG_MULT_LSB      0

// Rate multiplier codes.
`define VRMS_MULT_NOMINAL      2'h0
`define VRMS_MULT_SLOW         2'h1
`define VRMS_MULT_FAST         2'h2
`define VRMS_SLOW_SHIFT        3
`define VRMS_FAST_SHIFT        1

// Reset values.
`define VRMS_OP_RESET          8'h00
`define VRMS_SETPOINT_RESET    9'h000
`define VRMS_CFG_RESET         8'h00

// Timing.
`define VRMS_CLK_PERIOD_NS     100
`define VRMS_STEP_PCT_E4       1953
`define VRMS_DEFAULT_SR_PCT_MS 23
`define VRMS_BYPASS_NS         100
`define VRMS_CAP_W             16
`define VRMS_PERIOD_W          20

`endif

// ---- src/vrms_pkg.sv ----
// Types shared by the reference setpoint and slew ramp block.
package vrms_pkg;
`include "vrms_params.svh"

    typedef enum logic [1:0] {
        VRMS_SRC_NOMINAL,
        VRMS_SRC_LOWER,
        VRMS_SRC_UPPER
    } vrms_src_t;

    typedef struct packed {
        logic                      strobe;
        logic [`VRMS_CMD_W-1:0]    cmd;
        logic [15:0]               data;
    } vrms_wr_t;

    typedef struct packed {
        logic [7:0]                   operation_control;
        logic [`VRMS_SETPOINT_W-1:0]  nominal_setpoint;
        logic [`VRMS_SETPOINT_W-1:0]  upper_trim_setpoint;
        logic [`VRMS_SETPOINT_W-1:0]  lower_trim_setpoint;
        logic [7:0]                   vendor_config_byte;
    } vrms_regs_t;

    typedef struct packed {
        vrms_regs_t                   regs;
        logic [`VRMS_SETPOINT_W-1:0]  ref_code;
        logic [15:0]                  rd_data;
        logic                         run_s1;
        logic                         run_s2;
        logic                         open_s1;
        logic                         open_s2;
        logic                         tied_s1;
        logic                         tied_s2;
        logic [`VRMS_CAP_W-1:0]       cap_s1;
        logic [`VRMS_CAP_W-1:0]       cap_s2;
    } vrms_state_t;

    typedef struct packed {
        logic [`VRMS_PERIOD_W-1:0]    count;
    } vrms_timer_t;

endpackage : vrms_pkg

// ---- src/vrms_step_timer.sv ----
// Step timer that paces reference ramp steps as one-cycle ticks.
`timescale 1ns/1ns
`include "vrms_params.svh"
module vrms_step_timer
    import vrms_pkg::*;
(
    input  wire logic                      CLOCK,  // System clock.
    input  wire logic                      ARST_N, // Async reset, low.
    input  wire logic                      clear,  // Restart the count.
    input  wire logic [`VRMS_PERIOD_W-1:0] period, // Cycles per step.
    output logic                           tick    // Step enable pulse.
);
    localparam logic [`VRMS_PERIOD_W-1:0] ONE = `VRMS_PERIOD_W'(1);

    vrms_timer_t st_r;
    vrms_timer_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        tick   = 1'b0;
        if (clear)
        begin
            st_nxt.count = '0;
        end
        // A shortened period mid-count fires at once instead of wrapping.
        else if (st_r.count >= period - ONE)
        begin
            tick         = 1'b1;
            st_nxt.count = '0;
        end
        else
        begin
            st_nxt.count = st_r.count + ONE;
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

endmodule : vrms_step_timer

// ---- src/vrms_top.sv ----
// Reference setpoint selection with margining and slew-limited ramp.
// How it works
// - Reference follows a 9-bit setpoint, 0 to 100 percent of full scale.
// - Operation bits 5:4 pick nominal, lower trim or upper trim setpoint.
// - Both margin bits set is illegal; nominal setpoint is then used.
// - On target change the reference steps one code at a time toward it.
// - Step duration from slew capacitor, shortened or lengthened by multiplier.
// - Open slew pin gives a default rate of 23 percent per millisecond.
// - Slew pin tied to filtered supply jumps reference within 100 ns.
// - Setpoint registers hold 9 unsigned bits from two data bytes.
// - Vendor config bits 1:0 pick nominal, eighth or double rate.
// - Operation byte values 00, 80, 98 and A8 switch off, on, margins.
// - Power-on, manufacturer reset and run low clear setpoints to zero.
`timescale 1ns/1ns
`include "vrms_params.svh"
module vrms_top
    import vrms_pkg::*;
#(
    // Cycles per step with the slew pin open (default rate).
    parameter int DEFAULT_STEP_CYCLES =
        (`VRMS_STEP_PCT_E4 * 100) /
        (`VRMS_DEFAULT_SR_PCT_MS * `VRMS_CLK_PERIOD_NS)
)
(
    input  wire logic                        CLOCK,            // 10 MHz.
    input  wire logic                        ARST_N,           // Reset, low.
    input  wire vrms_wr_t                    WR,               // Write port.
    input  wire logic                        RD_STROBE,        // Read request.
    input  wire logic [`VRMS_CMD_W-1:0]      RD_CMD,           // Read select.
    input  wire logic                        RUN,              // Run pin.
    input  wire logic                        CSLEW_OPEN,       // Pin open.
    input  wire logic                        CSLEW_TIED,       // Pin to rail.
    input  wire logic [`VRMS_CAP_W-1:0]      CSLEW_CAP_CYCLES, // Base step.
    output logic [15:0]                      RD_DATA,          // Read data.
    output logic [`VRMS_SETPOINT_W-1:0]      REF_CODE,         // Reference.
    output logic                             VOUT_ON,          // Output on.
    output logic                             RAMPING           // Moving.
);
    localparam int PW = `VRMS_PERIOD_W;
    localparam int SW = `VRMS_SETPOINT_W;
    localparam int BYPASS_CYCLES = `VRMS_BYPASS_NS / `VRMS_CLK_PERIOD_NS;

    if (DEFAULT_STEP_CYCLES < 1 || DEFAULT_STEP_CYCLES >= (1 << (PW - 4)))
    begin : g_chk
        $error("DEFAULT_STEP_CYCLES out of range");
    end

    vrms_state_t st_r;
    vrms_state_t st_nxt;
    logic        tick;
    logic        timer_clear;
    logic [PW-1:0] period;
    logic [SW-1:0] target;

    function automatic vrms_src_t select_src(input logic [7:0] op);
        vrms_src_t s;
        s = VRMS_SRC_NOMINAL;
        if (op[`VRMS_OP_MARGIN_HI_BIT] && !op[`VRMS_OP_MARGIN_LO_BIT])
            s = VRMS_SRC_UPPER;
        else if (!op[`VRMS_OP_MARGIN_HI_BIT] && op[`VRMS_OP_MARGIN_LO_BIT])
            s = VRMS_SRC_LOWER;
        return s;
    endfunction : select_src

    function automatic logic [SW-1:0] select_target(input vrms_regs_t r);
        logic [SW-1:0] t;
        case (select_src(r.operation_control))
            VRMS_SRC_LOWER: t = r.lower_trim_setpoint;
            VRMS_SRC_UPPER: t = r.upper_trim_setpoint;
            default:        t = r.nominal_setpoint;
        endcase
        return t;
    endfunction : select_target

    function automatic logic [PW-1:0] step_period(
        input logic                   open,
        input logic [`VRMS_CAP_W-1:0] cap,
        input logic [1:0]             mult
    );
        logic [PW-1:0] base;
        logic [PW-1:0] p;
        base = open ? PW'(DEFAULT_STEP_CYCLES) : PW'(cap);
        case (mult)
            `VRMS_MULT_SLOW: p = base << `VRMS_SLOW_SHIFT;
            `VRMS_MULT_FAST: p = base >> `VRMS_FAST_SHIFT;
            default:         p = base;
        endcase
        if (p == '0)
            p = PW'(1);
        return p;
    endfunction : step_period

    function automatic logic [SW-1:0] code_dist(input logic [SW-1:0] a,
                                                 input logic [SW-1:0] b);
        return (a > b) ? a - b : b - a;
    endfunction : code_dist

    assign target = select_target(st_r.regs);
    assign period = step_period(st_r.open_s2, st_r.cap_s2,
        st_r.regs.vendor_config_byte[`VRMS_CFG_MULT_MSB:`VRMS_CFG_MULT_LSB]);
    // stop on target
    // Holding the timer while idle makes the first step a full period long.
    assign timer_clear = (st_r.ref_code == target) || st_r.tied_s2;

    vrms_step_timer u_timer (
        .CLOCK  (CLOCK),
        .ARST_N (ARST_N),
        .clear  (timer_clear),
        .period (period),
        .tick   (tick)
    );

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.run_s1  = RUN;
        st_nxt.run_s2  = st_r.run_s1;
        st_nxt.open_s1 = CSLEW_OPEN;
        st_nxt.open_s2 = st_r.open_s1;
        st_nxt.tied_s1 = CSLEW_TIED;
        st_nxt.tied_s2 = st_r.tied_s1;
        st_nxt.cap_s1  = CSLEW_CAP_CYCLES;
        st_nxt.cap_s2  = st_r.cap_s1;

        if (WR.strobe)
        begin
            if (WR.cmd == `VRMS_CMD_OPERATION)
                st_nxt.regs.operation_control = WR.data[7:0];
            else if (WR.cmd == `VRMS_CMD_NOMINAL)
                st_nxt.regs.nominal_setpoint = WR.data[SW-1:0];
            else if (WR.cmd == `VRMS_CMD_UPPER_TRIM)
                st_nxt.regs.upper_trim_setpoint = WR.data[SW-1:0];
            else if (WR.cmd == `VRMS_CMD_LOWER_TRIM)
                st_nxt.regs.lower_trim_setpoint = WR.data[SW-1:0];
            else if (WR.cmd == `VRMS_CMD_VENDOR_CFG)
                st_nxt.regs.vendor_config_byte = WR.data[7:0];
        end

        if ((WR.strobe && WR.cmd == `VRMS_CMD_MFR_RESET) || !st_r.run_s2)
        begin
            st_nxt.regs.operation_control   = `VRMS_OP_RESET;
            st_nxt.regs.nominal_setpoint    = `VRMS_SETPOINT_RESET;
            st_nxt.regs.upper_trim_setpoint = `VRMS_SETPOINT_RESET;
            st_nxt.regs.lower_trim_setpoint = `VRMS_SETPOINT_RESET;
            st_nxt.regs.vendor_config_byte  = `VRMS_CFG_RESET;
        end

        if (st_r.tied_s2)
            st_nxt.ref_code = target;
        else if (tick && st_r.ref_code < target)
            st_nxt.ref_code = st_r.ref_code + SW'(1);
        else if (tick && st_r.ref_code > target)
            st_nxt.ref_code = st_r.ref_code - SW'(1);

        if (RD_STROBE)
        begin
            if (RD_CMD == `VRMS_CMD_OPERATION)
                st_nxt.rd_data = {8'h00, st_r.regs.operation_control};
            else if (RD_CMD == `VRMS_CMD_NOMINAL)
                st_nxt.rd_data = {7'h00, st_r.regs.nominal_setpoint};
            else if (RD_CMD == `VRMS_CMD_UPPER_TRIM)
                st_nxt.rd_data = {7'h00, st_r.regs.upper_trim_setpoint};
            else if (RD_CMD == `VRMS_CMD_LOWER_TRIM)
                st_nxt.rd_data = {7'h00, st_r.regs.lower_trim_setpoint};
            else if (RD_CMD == `VRMS_CMD_VENDOR_CFG)
                st_nxt.rd_data = {8'h00, st_r.regs.vendor_config_byte};
            else
                st_nxt.rd_data = 16'h0000;
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign RD_DATA  = st_r.rd_data;
    assign REF_CODE = st_r.ref_code;
    assign VOUT_ON  = st_r.regs.operation_control[`VRMS_OP_ON_BIT];
    assign RAMPING  = (st_r.ref_code != target) && !st_r.tied_s2;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);

    sequence s_op_write(logic [7:0] v);
        WR.strobe && WR.cmd == `VRMS_CMD_OPERATION && WR.data[7:0] == v
            && st_r.run_s2;
    endsequence

    sequence s_target_steady;
        $stable(target) [*2];
    endsequence

    nominal_write_a:
        assert property (WR.strobe && WR.cmd == `VRMS_CMD_NOMINAL
                         && st_r.run_s2 |=> st_r.regs.nominal_setpoint
                         == $past(WR.data[SW-1:0]))
        else $error("nominal setpoint write not stored");

    margin_select_a:
        assert property (st_r.regs.operation_control[5:4] == 2'h1
                         |-> target == st_r.regs.lower_trim_setpoint)
        else $error("lower trim not selected");

    illegal_margin_a:
        assert property (st_r.regs.operation_control[5:4] == 2'h3
                         |-> target == st_r.regs.nominal_setpoint)
        else $error("illegal margin code not ignored");

    step_size_a:
        assert property (!st_r.tied_s2 && !$past(st_r.tied_s2)
                         && $changed(st_r.ref_code)
                         |-> code_dist(st_r.ref_code, $past(st_r.ref_code))
                         == SW'(1))
        else $error("ramp step is not one code");

    fast_rate_a:
        assert property (!st_r.open_s2 && st_r.cap_s2 >= 16'h0002
                         && st_r.regs.vendor_config_byte[1:0] == 2'h2
                         |-> period == PW'(st_r.cap_s2) >> 1)
        else $error("fast multiplier period wrong");

    default_rate_a:
        assert property (st_r.open_s2
                         && st_r.regs.vendor_config_byte[1:0] == 2'h0
                         |-> period == PW'(DEFAULT_STEP_CYCLES))
        else $error("open pin default rate wrong");

    bypass_jump_a:
        assert property (st_r.tied_s2 && $stable(st_r.tied_s2)
                         && st_r.ref_code != target
                         |-> ##BYPASS_CYCLES st_r.ref_code == $past(target))
        else $error("bypass did not jump to target");

    no_overshoot_a:
        assert property (st_r.ref_code == target ##0 s_target_steady
                         |-> st_r.ref_code == target)
        else $error("ramp left its target");

    margin_low_cmd_a:
        assert property (s_op_write(8'h98) |=> VOUT_ON
                         && select_src(st_r.regs.operation_control)
                         == VRMS_SRC_LOWER)
        else $error("margin low command not taken");

    run_clear_a:
        assert property (!st_r.run_s2 |=> st_r.regs.nominal_setpoint
                         == `VRMS_SETPOINT_RESET && st_r.regs.lower_trim_setpoint
                         == `VRMS_SETPOINT_RESET && !VOUT_ON)
        else $error("run low did not clear registers");

endmodule : vrms_top

// ---- testbench/vout_reference_margin_slew_bench.sv ----
// Self-checking bench for the reference setpoint and slew ramp block.
`timescale 1ns/1ns
`include "vrms_params.svh"
module vout_reference_margin_slew_bench
    import vrms_pkg::*;
;
    localparam int DSC = 2;
    localparam logic [7:0] OPS [5] = '{8'h00, 8'h80, 8'h98, 8'hA8, 8'hB8};
    logic        clock = 1'b0;
    logic        arst_n, run, c_open, c_tied, mon;
    logic [15:0] cap;
    vrms_wr_t    wr;
    logic        rd_strobe;
    logic [2:0]  rd_cmd;
    logic [15:0] rd_data;
    logic [8:0]  ref_code, last_ref, nom, lo, hi;
    logic [7:0]  op, cfg;
    logic        vout_on, ramping;
    int          n_fail = 0;
    int          checks = 0;

    always #50 clock = ~clock;

    vrms_top #(.DEFAULT_STEP_CYCLES(DSC)) DUT (
        .CLOCK(clock), .ARST_N(arst_n), .WR(wr), .RD_STROBE(rd_strobe),
        .RD_CMD(rd_cmd), .RUN(run), .CSLEW_OPEN(c_open),
        .CSLEW_TIED(c_tied), .CSLEW_CAP_CYCLES(cap), .RD_DATA(rd_data),
        .REF_CODE(ref_code), .VOUT_ON(vout_on), .RAMPING(ramping));

    vrms_host_model host (.clk(clock), .rd_data(rd_data), .wr(wr),
        .rd_strobe(rd_strobe), .rd_cmd(rd_cmd));

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("Checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    function automatic logic [8:0] tgt();
        case (op[5:4])
            2'h1: return lo;
            2'h2: return hi;
            default: return nom;
        endcase
    endfunction : tgt

    function automatic int per(logic o, int c, logic [1:0] m);
        int b;
        b = o ? DSC : c;
        if (m == 2'h1)
            b = b << 3;
        else if (m == 2'h2)
            b = b >> 1;
        return (b == 0) ? 1 : b;
    endfunction : per

    function automatic logic [15:0] exp_rd(int k);
        case (k)
            0: return {8'h00, op};
            1: return {7'h00, nom};
            2: return {7'h00, hi};
            3: return {7'h00, lo};
            4: return {8'h00, cfg};
            default: return 16'h0000;
        endcase
    endfunction : exp_rd

    // Upper data bits are random so that dropping them is exercised.
    task automatic put(input logic [2:0] c, input logic [8:0] v);
        host.write(c, {7'($urandom), v});
        case (c)
            3'h0: op = v[7:0];
            3'h1: nom = v;
            3'h2: hi = v;
            3'h3: lo = v;
            3'h4: cfg = v[7:0];
            default: ;
        endcase
    endtask : put

    task automatic clr;
        op = 8'h00;
        cfg = 8'h00;
        nom = 9'h000;
        lo = 9'h000;
        hi = 9'h000;
    endtask : clr

    task automatic read_all;
        logic [15:0] v;
        for (int k = 0; k < 8; k++)
        begin
            host.read(3'(k), v);
            chk("read", exp_rd(k), v);
        end
    endtask : read_all

    task automatic ramp(input logic [8:0] t, input int p);
        int last;
        int n;
        logic [8:0] prev;
        last = -1;
        n = 0;
        prev = ref_code;
        chk("ramp_busy", 16'h1, ramping);
        while (ref_code !== t && n < 4000)
        begin
            @(posedge clock);
            #1;
            n++;
            if (ref_code !== prev)
            begin
                chk("step_dir", t > prev, ref_code > prev);
                if (last >= 0)
                    chk("step_gap", 16'(p), 16'(n - last));
                last = n;
                prev = ref_code;
            end
        end
        repeat (p + 2) @(posedge clock);
        #1;
        chk("ramp_end", t, ref_code);
        chk("ramping", 16'h0, ramping);
    endtask : ramp

    // Sampled on the falling edge, where the reference has settled.
    always @(negedge clock)
    begin
        if (mon && ref_code !== last_ref)
            chk("step_size", 16'h1, (ref_code > last_ref) ?
                ref_code - last_ref : last_ref - ref_code);
        last_ref <= ref_code;
    end

    initial
    begin
        // The whole run needs under about a thousand cycles; this leaves ample margin.
        #(100 * 20000);
        n_fail++;
        report_and_stop;
    end

    initial
    begin
        logic [8:0] nv;
        int p;
        void'($urandom(68016));
        arst_n = 1'b0;
        run = 1'b1;
        c_open = 1'b0;
        c_tied = 1'b1;
        cap = 16'h0003;
        mon = 1'b0;
        clr();
        repeat (16) @(posedge clock);
        #1;
        arst_n = 1'b1;
        chk("ref_rst", 16'h0, ref_code);
        chk("on_rst", 16'h0, vout_on);
        repeat (3) @(posedge clock);
        for (int i = 0; i < 6; i++)
        begin
            put(`VRMS_CMD_NOMINAL, 9'($urandom));
            put(`VRMS_CMD_UPPER_TRIM, 9'($urandom));
            put(`VRMS_CMD_LOWER_TRIM, 9'($urandom));
            put(`VRMS_CMD_VENDOR_CFG, 9'($urandom_range(255)));
            foreach (OPS[k])
            begin
                put(`VRMS_CMD_OPERATION, {1'b0, OPS[k]});
                // The bypassed reference follows one cycle after the write.
                @(posedge clock);
                #1;
                chk("ref_sel", tgt(), ref_code);
                chk("vout_on", op[7], vout_on);
            end
            read_all();
        end
        put(`VRMS_CMD_MFR_RESET, 9'h1FF);
        clr();
        @(posedge clock);
        #1;
        chk("ref_mfr", 16'h0, ref_code);
        chk("on_mfr", 16'h0, vout_on);
        read_all();
        put(`VRMS_CMD_NOMINAL, 9'h1FF);
        run = 1'b0;
        repeat (4) @(posedge clock);
        #1;
        run = 1'b1;
        clr();
        repeat (3) @(posedge clock);
        read_all();
        c_tied = 1'b0;
        put(`VRMS_CMD_OPERATION, 9'h080);
        repeat (3) @(posedge clock);
        mon = 1'b1;
        p = 1;
        for (int m = 0; m < 4; m++)
            for (int o = 0; o < 2; o++)
            begin
                cap = 16'(2 + $urandom_range(3));
                c_open = o[0];
                repeat (3) @(posedge clock);
                put(`VRMS_CMD_VENDOR_CFG, 9'(m));
                p = per(o[0], int'(cap), m[1:0]);
                nv = 9'(1 + $urandom_range(7));
                nv = (nom > 9'h008 && $urandom_range(1) == 1) ?
                    nom - nv : nom + nv;
                put(`VRMS_CMD_NOMINAL, nv);
                ramp(nv, p);
            end
        nv = nom;
        put(`VRMS_CMD_NOMINAL, nv + 9'h014);
        repeat (5 * p) @(posedge clock);
        put(`VRMS_CMD_NOMINAL, nv);
        ramp(nv, p);
        report_and_stop;
    end
endmodule : vout_reference_margin_slew_bench

// ---- testbench/vrms_host_model.sv ----
// Host model that writes and reads the setpoint registers.
`timescale 1ns/1ns
module vrms_host_model
    import vrms_pkg::*;
(
    input  wire logic        clk,       // System clock.
    input  wire logic [15:0] rd_data,   // Read data from the block.
    output vrms_wr_t         wr,        // Write port.
    output logic             rd_strobe, // Read request.
    output logic [2:0]       rd_cmd     // Read select.
);
    initial
    begin
        wr = '0;
        rd_strobe = 1'b0;
        rd_cmd = 3'h7;
    end

    // Idle fields show inverted values so stale data never looks valid.
    // margin bits follow the caller
    task automatic write(input logic [2:0] c, input logic [15:0] d);
        @(posedge clk);
        #1;
        wr = {1'b1, c, d};
        @(posedge clk);
        #1;
        wr = {1'b0, ~c, ~d};
    endtask : write

    task automatic read(input logic [2:0] c, output logic [15:0] v);
        @(posedge clk);
        #1;
        rd_strobe = 1'b1;
        rd_cmd = c;
        @(posedge clk);
        #1;
        rd_strobe = 1'b0;
        rd_cmd = ~c;
        v = rd_data;
    endtask : read
endmodule : vrms_host_model
